// file: sip_pkg.sv
// package of constants and types for the stepper indexer position block
// ==========================================================================
package sip_pkg;
  // ==========================================================================
  // bus and register map
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_INDEX = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_COIL_A_EXPECTED_CURRENT = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PERIOD = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // control register fields
  localparam int B_EDGE_SEL = 0;
  localparam int B_STEP_OVR = 1;
  localparam int B_DIR_OVR = 2;
  localparam int B_DIR = 3;
  localparam int B_STEP = 4;
  localparam int B_INDEXER_RESET_BIT = 5;
  localparam int B_BYPASS = 6;
  localparam int B_TOL_LO = 7;
  localparam int B_RES_LO = 9;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0080;
  // ==========================================================================
  // index register fields
  localparam int B_A_POS_LO = 0;
  localparam int B_B_POS_LO = 8;
  localparam int B_A_SIGN = 16;
  localparam int B_B_SIGN = 17;
  localparam int B_HOME_STAT = 18;
  // ==========================================================================
  // indexer
  localparam int POS_W = 10;
  localparam logic [POS_W-1:0] POS_HOME = 10'h080;
  localparam logic [3:0] RES_FINEST = 4'h8;
  localparam int PER_W = 20;
  localparam logic [PER_W-1:0] PER_MAX = 20'hF_FFFF;
  // pin vector order
  localparam int PIN_STEP = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_HW = 2;
  localparam int PIN_SLEEP = 3;
  localparam int PIN_UVLO = 4;
  localparam int PIN_N = 5;
  typedef enum logic [1:0] {
    SIP_TOL_1 = 2'b00,
    SIP_TOL_2 = 2'b01,
    SIP_TOL_4 = 2'b10,
    SIP_TOL_6 = 2'b11
  } sip_tol_t;
endpackage

// file: sip_indexer.sv
// stepper indexer: step/direction sequencing, readback, home pin, jitter filter
`timescale 1ns/1ps
module sip_indexer
  import sip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_step_pin,
  input wire logic i_dir_pin,
  input wire logic i_hw_mode,
  input wire logic i_sleep,
  input wire logic i_logic_uvlo,
  input wire logic [AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_home_out_n,
  output logic o_home_oe,
  output logic o_clean_step
);
  // ==========================================================================
  // functions
  function automatic logic [POS_W-1:0] step_inc(input logic [3:0] res);
    logic [3:0] r;
    r = (res > RES_FINEST) ? RES_FINEST : res;
    step_inc = POS_W'(10'h100 >> r);
  endfunction

  function automatic logic [POS_W-1:0] next_pos(input logic [POS_W-1:0] pos,
                                                input logic [3:0] res,
                                                input logic fwd);
    logic [POS_W-1:0] off;
    logic [POS_W-1:0] inc;
    logic [POS_W-1:0] p;
    logic [POS_W-1:0] al;
    logic [POS_W-1:0] n;
    // full step sits on the odd 45 degree grid, finer modes on multiples of inc
    off = (res == 4'h0) ? POS_HOME : 10'h000;
    inc = step_inc(res);
    p = pos - off;
    al = p & ~(inc - 10'h001);
    if (fwd) begin
      n = al + inc;
    end else begin
      n = (p == al) ? (al - inc) : al;
    end
    next_pos = n + off;
  endfunction

  // sine at every sixteenth position, scaled to 255; entry 16 is the peak
  localparam logic [16:0][7:0] SINE_PTS = {8'hFF, 8'hFE, 8'hFA, 8'hF4, 8'hEC, 8'hE1,
                                           8'hD5, 8'hC6, 8'hB5, 8'hA2, 8'h8E, 8'h79,
                                           8'h62, 8'h4A, 8'h32, 8'h19, 8'h00};
  function automatic logic [7:0] sine_pt(input logic [4:0] k);
    sine_pt = k[4] ? 8'hFF : SINE_PTS[k[3:0]];
  endfunction
  // interpolated sin(90 * pos / 256) scaled to 255
  function automatic logic [7:0] sine_of(input logic [7:0] pos);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [11:0] d;
    lo = sine_pt({1'b0, pos[7:4]});
    hi = sine_pt({1'b0, pos[7:4]} + 5'd1);
    d = 12'(hi - lo) * 12'(pos[3:0]);
    sine_of = lo + d[11:4];
  endfunction

  function automatic logic [6:0] tol_pct(input sip_tol_t t);
    case (t)
      SIP_TOL_1: tol_pct = 7'd1;
      SIP_TOL_2: tol_pct = 7'd2;
      SIP_TOL_4: tol_pct = 7'd4;
      default: tol_pct = 7'd6;
    endcase
  endfunction

  // ==========================================================================
  // pin synchronisers
  logic [PIN_N-1:0] pin_s1_q;
  logic [PIN_N-1:0] pin_s2_q;
  logic [PIN_N-1:0] pin_s3_q;
  logic [PIN_N-1:0] pin_lvl_q;
  logic [PIN_N-1:0] pin_lvl_d;
  logic [PIN_N-1:0] pin_raw;
  assign pin_raw = {i_logic_uvlo, i_sleep, i_hw_mode, i_dir_pin, i_step_pin};
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_lvl_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // a level changes only once two stages agree
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      pin_lvl_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s3_q[i] : pin_lvl_q[i];
    end
  end

  logic hw_mode;
  logic soft_rst;
  logic step_rise;
  logic step_fall;

  assign hw_mode = pin_lvl_q[PIN_HW];
  // registers and indexer held at default through sleep and undervoltage
  assign soft_rst = pin_lvl_q[PIN_SLEEP] | pin_lvl_q[PIN_UVLO];
  assign step_rise = pin_lvl_d[PIN_STEP] & ~pin_lvl_q[PIN_STEP];
  assign step_fall = ~pin_lvl_d[PIN_STEP] & pin_lvl_q[PIN_STEP];

  // ==========================================================================
  // axi4-lite slave
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_go;
  logic [CTRL_W-1:0] ctrl_q;
  logic [7:0] a_pos_q;
  logic [7:0] b_pos_q;
  logic a_sign_q;
  logic b_sign_q;
  logic [7:0] coil_a_expected_current_q;
  logic [PER_W-1:0] avg_per_q;
  logic [POS_W-1:0] pos_q;
  assign wr_go = aw_have_q & w_have_q & ~o_bvalid;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_addr_q <= i_awaddr;
        aw_have_q <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
        w_have_q <= 1'b1;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_INDEX ||
                    aw_addr_q == OFS_COIL_A_EXPECTED_CURRENT || aw_addr_q == OFS_PERIOD) ?
                   RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      case (i_araddr)
        OFS_CTRL: o_rdata <= 32'(ctrl_q);
        OFS_INDEX: o_rdata <= 32'({pos_q != POS_HOME, b_sign_q, a_sign_q, b_pos_q,
                                   a_pos_q});
        OFS_COIL_A_EXPECTED_CURRENT: o_rdata <= 32'(coil_a_expected_current_q);
        OFS_PERIOD: o_rdata <= 32'(avg_per_q);
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // control register; step and indexer reset bits are one-shot and read zero
  logic ctrl_wr;
  logic step_bit_pulse;
  logic indexer_reset_bit_pulse;
  logic [CTRL_W-1:0] ctrl_wv;
  assign ctrl_wr = wr_go && (aw_addr_q == OFS_CTRL);
  assign ctrl_wv = {w_strb_q[1] ? w_data_q[CTRL_W-1:8] : ctrl_q[CTRL_W-1:8],
                    w_strb_q[0] ? w_data_q[7:0] : ctrl_q[7:0]};
  assign step_bit_pulse = ctrl_wr & w_strb_q[0] & w_data_q[B_STEP] &
                          ctrl_wv[B_STEP_OVR] & ~hw_mode;
  assign indexer_reset_bit_pulse = ctrl_wr & w_strb_q[0] & w_data_q[B_INDEXER_RESET_BIT] & ~hw_mode;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (soft_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_wv & ~(CTRL_W'(1) << B_STEP) & ~(CTRL_W'(1) << B_INDEXER_RESET_BIT);
    end
  end

  // ==========================================================================
  // step and direction selection
  logic act_step;
  logic fwd;
  logic [3:0] res;
  logic [CTRL_W-1:0] ctrl_now;
  assign res = ctrl_q[B_RES_LO +: 4];
  // the write that sets an override already steers the step it carries
  assign ctrl_now = ctrl_wr ? ctrl_wv : ctrl_q;
  always_comb begin
    if (hw_mode) begin
      act_step = step_rise;
      fwd = pin_lvl_q[PIN_DIR];
    end else begin
      if (ctrl_now[B_STEP_OVR]) begin
        act_step = step_bit_pulse;
      end else begin
        act_step = step_rise | (ctrl_now[B_EDGE_SEL] & step_fall);
      end
      fwd = ctrl_now[B_DIR_OVR] ? ctrl_now[B_DIR] : pin_lvl_q[PIN_DIR];
    end
  end

  // ==========================================================================
  // indexer position, 1024 states per electrical turn
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q <= POS_HOME;
    end else if (soft_rst || indexer_reset_bit_pulse) begin
      pos_q <= POS_HOME;
    end else if (act_step) begin
      pos_q <= next_pos(pos_q, res, fwd);
    end
  end

  // ==========================================================================
  // readback and home pin
  logic [7:0] a_lin;
  assign a_lin = pos_q[8] ? ~pos_q[7:0] : pos_q[7:0];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      a_pos_q <= 8'h80;
      b_pos_q <= 8'h7F;
      a_sign_q <= 1'b1;
      b_sign_q <= 1'b1;
      coil_a_expected_current_q <= 8'h00;
      o_home_oe <= 1'b0;
      o_home_out_n <= 1'b0;
    end else begin
      a_pos_q <= a_lin;
      b_pos_q <= ~a_lin;
      a_sign_q <= ~pos_q[9];
      b_sign_q <= ~(pos_q[9] ^ pos_q[8]);
      coil_a_expected_current_q <= sine_of(a_pos_q);
      // pin pulled low once per turn, i.e. every four full steps
      o_home_oe <= (pos_q == POS_HOME);
      o_home_out_n <= 1'b0;
    end
  end

  // ==========================================================================
  // step-rate jitter filter feeding stall detection only
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] cln_cnt_q;
  logic [PER_W-1:0] diff;
  logic in_tol;
  assign diff = (per_cnt_q > avg_per_q) ? (per_cnt_q - avg_per_q) : (avg_per_q - per_cnt_q);
  assign in_tol = (27'(diff) * 27'd100) <=
                  (27'(tol_pct(sip_tol_t'(ctrl_q[B_TOL_LO +: 2]))) * 27'(avg_per_q));
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      per_cnt_q <= '0;
      cln_cnt_q <= '0;
      avg_per_q <= '0;
      o_clean_step <= 1'b0;
    end else if (soft_rst) begin
      per_cnt_q <= '0;
      cln_cnt_q <= '0;
      avg_per_q <= '0;
      o_clean_step <= 1'b0;
    end else begin
      per_cnt_q <= (per_cnt_q == PER_MAX) ? PER_MAX : per_cnt_q + PER_W'(1);
      cln_cnt_q <= (cln_cnt_q == PER_MAX) ? PER_MAX : cln_cnt_q + PER_W'(1);
      o_clean_step <= 1'b0;
      if (act_step) begin
        per_cnt_q <= PER_W'(1); // the step's own cycle belongs to the new period
      end
      if (ctrl_q[B_BYPASS]) begin
        o_clean_step <= act_step;
        if (act_step) begin
          avg_per_q <= per_cnt_q;
        end
      end else if (act_step && !in_tol) begin
        // a real rate change resynchronises the clean train; never two pulses in a row
        avg_per_q <= per_cnt_q;
        cln_cnt_q <= '0;
        o_clean_step <= !o_clean_step;
      end else if (avg_per_q != '0 && cln_cnt_q >= avg_per_q - PER_W'(1)) begin
        cln_cnt_q <= '0;
        o_clean_step <= !o_clean_step;
      end
    end
  end
endmodule

// file: sip_indexer_assertions.sv
// checker for bus handshakes, home pin and filtered step of the indexer
`timescale 1ns/1ps
module sip_indexer_chk
  import sip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sleep,
  input wire logic i_logic_uvlo,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_home_out_n,
  input wire logic o_home_oe,
  input wire logic o_clean_step
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // assertions
  a_home_level: assert property (!o_home_out_n)
    else $error("home pin drive level not low");
  a_home_after_rst: assert property ($fell(i_rst) |-> ##[0:2] o_home_oe)
    else $error("indexer not home after reset");
  // sleep and undervoltage pass a synchroniser before they reset the indexer
  a_sleep_home: assert property ((i_sleep || i_logic_uvlo) [*8] |-> o_home_oe)
    else $error("indexer not home during sleep or undervoltage");
  a_clean_pulse: assert property (o_clean_step |=> !o_clean_step)
    else $error("clean step longer than one cycle");
  a_write_answer: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
    else $error("write response missing");
  a_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer late");
  a_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  c_write: cover property (o_bvalid && i_bready);
  c_slverr: cover property (o_rvalid && o_rresp == RESP_SLVERR);
  c_clean: cover property (o_clean_step);
  c_home_left: cover property ($fell(o_home_oe));
endmodule
bind sip_indexer sip_indexer_chk u_chk (.*);

// file: sip_host_model.sv
// host motion controller model driving the step and direction pins
`timescale 1ns/1ps
module sip_host_model (
  input wire logic i_sys_clk,
  output logic o_step,
  output logic o_dir
);
  initial begin
    o_step = 1'b0;
    o_dir = 1'b1;
  end
  task automatic set_dir(input logic d);
    @(posedge i_sys_clk);
    o_dir <= d;
  endtask
  // each level is held several cycles so the pin synchroniser sees it once
  task automatic pulse(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge i_sys_clk);
      o_step <= 1'b1;
      repeat (half) @(posedge i_sys_clk);
      o_step <= 1'b0;
    end
  endtask
endmodule

// file: sip_indexer_tb.sv
// self-checking bench for the stepper indexer position block
`timescale 1ns/1ps
module sip_indexer_tb;
  import sip_pkg::*;
  logic clk, rst, hw, slp, uv, step, dir, hn, hoe, cs;
  logic awv, wv, bv, br, arv, rv, rr, awr, wr_rdy, arr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bre, rre;
  logic [9:0] pos;
  int fails, n_compared, n_clean;
  sip_host_model u_host (.i_sys_clk(clk), .o_step(step), .o_dir(dir));
  sip_indexer u_dut (.i_sys_clk(clk), .i_rst(rst), .i_step_pin(step), .i_dir_pin(dir),
    .i_hw_mode(hw), .i_sleep(slp), .i_logic_uvlo(uv), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr_rdy),
    .o_bresp(bre), .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rre), .o_rvalid(rv), .i_rready(rr),
    .o_home_out_n(hn), .o_home_oe(hoe), .o_clean_step(cs));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cs === 1'b1) n_clean++;
  end
  // ==========================================================================
  // compare and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_near(input logic [7:0] g, input int e, input string m);
    n_compared++;
    if ($isunknown(g) || int'(g) < e - 2 || int'(g) > e + 2) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %0d", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv);
    chk({30'h0, bre}, {30'h0, RESP_OKAY}, "bresp");
    br <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rre;
    rr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "rresp");
    chk(d, e, "rdata");
  endtask
  function automatic logic [31:0] idx_exp(input logic [9:0] p);
    logic [7:0] a;
    a = p[8] ? 8'hFF - p[7:0] : p[7:0];
    return {13'h0, p != POS_HOME, p[9:8] == 2'h0 || p[9:8] == 2'h3, !p[9], 8'hFF - a, a};
  endfunction
  task automatic chk_pos();
    rd_chk(OFS_INDEX, idx_exp(pos), RESP_OKAY);
    chk({31'h0, hoe}, {31'h0, pos == POS_HOME}, "home pin");
    chk({31'h0, hn}, 32'h0000_0000, "home drive level");
  endtask
  task automatic pls(input int n);
    u_host.pulse(n, 4);
    repeat (8) @(posedge clk);
  endtask
  task automatic gp(input int g);
    repeat (g) @(posedge clk);
    u_host.pulse(1, 4);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_defaults();
    logic [31:0] v;
    logic [1:0] r;
    pos = POS_HOME;
    rd_chk(OFS_CTRL, 32'h0000_0080, RESP_OKAY);
    chk_pos();
    rd(OFS_COIL_A_EXPECTED_CURRENT, v, r);
    chk_near(v[7:0], 181, "coil a current at home");
    rd_chk(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_INDEX, 32'h0000_0000);
    chk_pos();
  endtask
  task automatic t_pin_walk();
    hw <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0081);
    repeat (4) begin
      pls(1);
      pos = pos + 10'h100;
      chk_pos();
    end
    hw <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_edges();
    pls(1);
    pos = pos + 10'h200;
    chk_pos();
    u_host.set_dir(1'b0);
    pls(1);
    pos = pos - 10'h200;
    chk_pos();
    wr(OFS_CTRL, 32'h0000_0080);
    pls(1);
    pos = pos - 10'h100;
    chk_pos();
  endtask
  task automatic t_override();
    wr(OFS_CTRL, 32'h0000_009E);
    repeat (8) @(posedge clk);
    pos = pos + 10'h100;
    chk_pos();
    rd_chk(OFS_CTRL, 32'h0000_008E, RESP_OKAY);
    pls(1);
    chk_pos();
    wr(OFS_CTRL, 32'h0000_0096);
    repeat (8) @(posedge clk);
    pos = pos - 10'h100;
    chk_pos();
  endtask
  task automatic t_indexer_reset_bit();
    wr(OFS_CTRL, 32'h0000_00A6);
    repeat (8) @(posedge clk);
    pos = POS_HOME;
    chk_pos();
    rd_chk(OFS_CTRL, 32'h0000_0086, RESP_OKAY);
  endtask
  task automatic t_res();
    logic [31:0] v;
    logic [1:0] r;
    u_host.set_dir(1'b1);
    wr(OFS_CTRL, 32'h0000_0280);
    pls(1);
    pos = 10'h100;
    chk_pos();
    rd(OFS_COIL_A_EXPECTED_CURRENT, v, r);
    chk_near(v[7:0], 255, "coil a current at peak");
    wr(OFS_CTRL, 32'h0000_0080);
    pls(1);
    pos = 10'h180;
    chk_pos();
  endtask
  task automatic t_filter();
    wr(OFS_CTRL, 32'h0000_00C0);
    repeat (4) @(posedge clk);
    n_clean = 0;
    pls(3);
    chk(n_clean, 3, "clean steps in bypass");
    // intervals 200, 200, 203: only the 1 percent code treats 203 as a new rate
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL, 32'(c) << 7);
      gp(0);
      gp(192);
      gp(192);
      gp(195);
      repeat (8) @(posedge clk);
      rd_chk(OFS_PERIOD, (c == 0) ? 32'h0000_00CB : 32'h0000_00C8, RESP_OKAY);
      rd_chk(OFS_CTRL, 32'(c) << 7, RESP_OKAY);
    end
  endtask
  task automatic t_sleep();
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 32'h0000_0041);
      pls(1);
      if (k == 0) slp <= 1'b1;
      else uv <= 1'b1;
      repeat (10) @(posedge clk);
      slp <= 1'b0;
      uv <= 1'b0;
      repeat (8) @(posedge clk);
      pos = POS_HOME;
      rd_chk(OFS_CTRL, 32'h0000_0080, RESP_OKAY);
      chk_pos();
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1; hw = 1'b0; slp = 1'b0; uv = 1'b0;
    awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0000_0000;
    fails = 0; n_compared = 0; n_clean = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_defaults();
    t_pin_walk();
    t_edges();
    t_override();
    t_indexer_reset_bit();
    t_res();
    t_filter();
    t_sleep();
    end_of_test();
  end
  // the whole run needs well under 10000 cycles
  initial begin
    #400_000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
